/* verif/sltag_core_chk.sv */
// Concurrent checks on the scan line tagging core ports
`timescale 1ns/100ps
`default_nettype none
module sltag_core_chk
	import sltag_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] timing_master_slave_select,
	input wire logic scan_begin_request,
	input wire logic standby_select,
	input wire logic [2:0] link_test_mode,
	input wire logic [7:0] fixed_word_hi,
	input wire logic [7:0] fixed_word_mid,
	input wire logic [7:0] fixed_word_lo,
	input wire logic line_transfer_pulse_q,
	input wire logic [20:0] pixel_word_q,
	input wire logic word_strobe_q,
	input wire logic scan_active_q,
	input wire logic scan_request_pending_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic mst; // Master timing selected
	logic [20:0] prev_q; // Last word taken
	logic [20:0] prev_d;
	logic ramp_q; // Last word was a ramp word
	logic ramp_d;
	logic off; // Tagged pixel data selected
	assign mst = !timing_master_slave_select[SLTAG_MS_SLAVE_BIT];
	assign off = link_test_mode == SLTAG_TEST_OFF;
	// Remember the previous word so the ramp step can be judged
	always_comb begin
		prev_d = word_strobe_q ? pixel_word_q : prev_q;
		ramp_d = word_strobe_q ? link_test_mode == SLTAG_TEST_RAMP : ramp_q;
	end
	// Plain registers for the helper state
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= '0;
			ramp_q <= 1'b0;
		end else begin
			prev_q <= prev_d;
			ramp_q <= ramp_d;
		end
	end
	property p_req_pend;
		scan_begin_request |=> scan_request_pending_q;
	endproperty
	a_req_pend: assert property (p_req_pend)
		else $error("request not held pending");
	property p_start;
		$rose(scan_active_q) |-> $past(scan_request_pending_q, 2);
	endproperty
	a_start: assert property (p_start)
		else $error("scan began without a request");
	property p_stby;
		mst && standby_select && scan_active_q |-> ##[1:40] !scan_active_q;
	endproperty
	a_stby: assert property (p_stby)
		else $error("standby did not stop the scan");
	property p_top_set;
		word_strobe_q && off && pixel_word_q[20]
		|-> line_transfer_pulse_q || $past(line_transfer_pulse_q);
	endproperty
	a_top_set: assert property (p_top_set)
		else $error("top tag bit high outside the pulse");
	property p_top_only;
		word_strobe_q && off && line_transfer_pulse_q
		&& $past(line_transfer_pulse_q, 2) |-> pixel_word_q[20];
	endproperty
	a_top_only: assert property (p_top_only)
		else $error("top tag bit low inside the pulse");
	property p_pulse_dummy;
		word_strobe_q && off && pixel_word_q[20] |-> pixel_word_q[19:16] == 4'h0;
	endproperty
	a_pulse_dummy: assert property (p_pulse_dummy)
		else $error("pulse word carries a pixel code");
	property p_ramp;
		word_strobe_q && link_test_mode == SLTAG_TEST_RAMP && ramp_q
		&& !scan_active_q |-> pixel_word_q == prev_q + 21'h000001;
	endproperty
	a_ramp: assert property (p_ramp)
		else $error("ramp did not step by one");
	property p_fixed;
		word_strobe_q && link_test_mode == SLTAG_TEST_FIXED
		|-> pixel_word_q == {fixed_word_hi[4:0], fixed_word_mid, fixed_word_lo};
	endproperty
	a_fixed: assert property (p_fixed)
		else $error("fixed word differs");
	property p_one_word;
		word_strobe_q |=> (!word_strobe_q) [*8];
	endproperty
	a_one_word: assert property (p_one_word)
		else $error("words closer than one link period");
endmodule : sltag_core_chk
bind sltag_core sltag_core_chk u_chk (
	.clk(clk), .rst_b(rst_b),
	.timing_master_slave_select(timing_master_slave_select),
	.scan_begin_request(scan_begin_request), .standby_select(standby_select),
	.link_test_mode(link_test_mode), .fixed_word_hi(fixed_word_hi),
	.fixed_word_mid(fixed_word_mid), .fixed_word_lo(fixed_word_lo),
	.line_transfer_pulse_q(line_transfer_pulse_q),
	.pixel_word_q(pixel_word_q), .word_strobe_q(word_strobe_q),
	.scan_active_q(scan_active_q),
	.scan_request_pending_q(scan_request_pending_q)
);
`default_nettype wire

/* verif/sltag_scanner_model.sv */
// Downstream scanner controller: link clock source and word sink
`timescale 1ns/100ps
`default_nettype none
module sltag_scanner_model
	import sltag_pkg::*;
(
	input wire logic clk,
	input wire logic run,
	input wire logic word_strobe_q,
	input wire logic [SLTAG_WORD_W-1:0] pixel_word_q,
	output logic link_clk,
	output logic [SLTAG_WORD_W-1:0] last_word,
	output var int words_seen
);
	// Link clock, 125 ns, parked low when the link is down
	initial begin
		link_clk = 1'b0;
		forever begin
			#62.5;
			link_clk = run ? ~link_clk : 1'b0;
		end
	end
	// Word with its five tag bits taken on the one-cycle strobe
	// One process owns the sink state, start values included
	initial begin
		last_word = '0;
		words_seen = 0;
		forever begin
			@(posedge clk);
			if (word_strobe_q === 1'b1) begin
				last_word <= pixel_word_q;
				words_seen <= words_seen + 1;
			end
		end
	end
endmodule : sltag_scanner_model
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the scan line tagging core
`timescale 1ns/100ps
`default_nettype none
module tb
	import sltag_pkg::*;
;
	`define CHK(nm, e, g) begin \
		num_checks++; \
		if ((g) !== (e)) begin \
			fails++; \
			$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
		end \
	end
	logic clk, rst_b, sync, req, stby, run, link_clk, pp;
	logic pulse, strobe, active, pend;
	logic [7:0] sel, wid, fhi, fmid, flo;
	logic [15:0] lend, bs, be, vs, ve, pdat;
	logic [2:0] col, mode;
	logic [20:0] word, lw, w, w2;
	logic [20:0] pat [4]; // Expected word per test mode
	int ws, np;
	int fails = 0;
	int num_checks = 0;
	sltag_core #(.COUNT_W(16)) uut (
		.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
		.line_sync_input(sync), .timing_master_slave_select(sel),
		.scan_begin_request(req), .standby_select(stby),
		.line_transfer_width(wid), .line_end_count(lend),
		.black_start(bs), .black_end(be), .valid_start(vs),
		.valid_end(ve), .colour_sel(col), .link_test_mode(mode),
		.fixed_word_hi(fhi), .fixed_word_mid(fmid), .fixed_word_lo(flo),
		.pixel_data(pdat), .line_transfer_pulse_q(pulse),
		.pixel_word_q(word), .word_strobe_q(strobe),
		.scan_active_q(active), .scan_request_pending_q(pend)
	);
	sltag_scanner_model far (
		.clk(clk), .run(run), .word_strobe_q(strobe), .pixel_word_q(word),
		.link_clk(link_clk), .last_word(lw), .words_seen(ws)
	);
	// Main clock never stops, serial accesses included
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Verdict and end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : wrap_up
	// Next word from the far end, bounded wait
	task automatic next_word(output logic [20:0] v);
		int n;
		n = ws;
		for (int i = 0; i < 40 && ws == n; i++) @(negedge clk);
		if (ws == n) begin
			fails++;
			wrap_up;
		end
		v = lw;
	endtask : next_word
	// Wait for a level on the line transfer pulse, bounded
	task automatic wait_lvl(input logic v);
		for (int i = 0; i < 600 && pulse !== v; i++) @(negedge clk);
		if (pulse !== v) begin
			fails++;
			wrap_up;
		end
	endtask : wait_lvl
	// Expected low tag of pixel k of a line
	function automatic logic [3:0] exp_tag(input int c, input int k);
		logic [3:0] blk [5];
		logic [3:0] act [5];
		blk = '{4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
		act = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
		if (k >= int'(bs) && k <= int'(be)) return blk[c];
		if (k >= int'(vs) && k <= int'(ve)) return act[c];
		return 4'h0;
	endfunction : exp_tag
	// Request a master scan and check two whole lines of words
	task automatic scan_lines(input int c);
		int pl;
		int k;
		logic inp;
		logic [3:0] et;
		pl = 0;
		k = 0;
		inp = 1'b0;
		np = 0;
		stby = 1'b0;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		`CHK("pending", 1'b1, pend)
		for (int i = 0; i < 100 && np < 3; i++) begin
			next_word(w);
			`CHK("data", pdat, w[15:0])
			if (w[20]) begin
				if (!inp && np > 0) `CHK("line_len", int'(lend), k)
				if (!inp) np++;
				pl = inp ? pl + 1 : 1;
				k = 0;
			end else begin
				if (inp) `CHK("pulse_len", int'(wid), pl)
				et = (np == 1 && k == 0) ? 4'hF : exp_tag(c, k);
				if (np == 0) et = 4'h0;
				`CHK("tag", et, w[19:16])
				k++;
			end
			inp = w[20];
		end
		// Bound used up without three line starts counts as a miss
		`CHK("lines", 3, np)
		stby = 1'b1;
		repeat (40) @(negedge clk);
		`CHK("stopped", 1'b0, active)
	endtask : scan_lines
	initial begin
		rst_b = 1'b0;
		{sync, req, pp} = 3'h0;
		stby = 1'b1;
		run = 1'b1;
		sel = 8'h00;
		wid = 8'h02;
		lend = 16'h0014;
		bs = 16'h0002;
		be = 16'h0004;
		vs = 16'h0004;
		ve = 16'h000F;
		pdat = 16'hA5C3;
		col = 3'h0;
		mode = SLTAG_TEST_OFF;
		fhi = 8'hF3;
		fmid = 8'h5A;
		flo = 8'hC6;
		pat = '{21'h0, 21'h155555, 21'h000000, {fhi[4:0], fmid, flo}};
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		`CHK("idle", 1'b0, active)
		for (int c = 0; c < 5; c++) begin
			col = c[2:0];
			scan_lines(c);
		end
		// Test modes inside a running scan, pulse holds the pattern
		wid = 8'h04;
		stby = 1'b0;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		for (int m = 1; m < 4; m++) begin
			next_word(w);
			mode = m[2:0];
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			repeat (2) @(negedge clk);
			for (int i = 0; i < 2; i++) begin
				next_word(w);
				`CHK("test_word", pat[m], w)
			end
		end
		next_word(w);
		mode = SLTAG_TEST_OFF;
		stby = 1'b1;
		repeat (40) @(negedge clk);
		// Free running patterns with no pulse
		next_word(w);
		mode = SLTAG_TEST_ALTERNATE;
		next_word(w);
		next_word(w2);
		`CHK("alt", ~w, w2)
		mode = SLTAG_TEST_RAMP;
		next_word(w);
		`CHK("ramp0", 21'h000000, w)
		next_word(w);
		`CHK("ramp1", 21'h000001, w)
		next_word(w);
		mode = SLTAG_TEST_OFF;
		// Slave timing: lines only on sync, long end count unused
		sel = 8'h01;
		lend = 16'h00C8;
		stby = 1'b0;
		req = 1'b1;
		@(negedge clk);
		req = 1'b0;
		repeat (500) @(negedge clk);
		`CHK("slave_wait", 1'b0, active)
		np = 0;
		for (int i = 0; i < 3; i++) begin
			sync = 1'b1;
			for (int j = 0; j < 375; j++) begin
				@(negedge clk);
				if (j == 5) sync = 1'b0;
				if (pulse && !pp) np++;
				pp = pulse;
			end
		end
		`CHK("slave_lines", 3, np)
		wrap_up;
	end
endmodule : tb
`default_nettype wire

/* verilog/sltag_core.sv */
// Line sequencer and tagged output word formatter
//
// Contract
// R1 - Master or slave timing per select register
// R2 - Scan request bit self clears, starts lines
// R3 - Master scan runs only while standby low
// R4 - Master line period from width and end
// R5 - Slave line starts on each sync pulse; the code ignores a sync that arrives while the pulse is still active
// R6 - Count pixels from pulse fall, compare windows
// R7 - Black window gives colour black code
// R8 - Valid window gives active code, else dummy
// R9 - Scan start marked with code 1111
// R10 - Five tag bits carried per word
// R11 - Top tag bit follows the pulse
// R12 - Test modes send full 21-bit pattern
// R13 - Pulse resets pattern; otherwise runs forever
// R14 - Mode 1 alternates base word, complement
// R15 - Mode 2 ramps by one per word
// R16 - Ramp starts at once, wraps continuously
// R17 - Mode 3 sends fixed upcounter word
// R18 - Sample phase leaves word position unchanged
// R19 - Main clock kept running during accesses
// R20 - No test mode sends tagged pixel data
`timescale 1ns/100ps
`default_nettype none
module sltag_core
	import sltag_pkg::*;
#(
	parameter int COUNT_W = 16
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_clk,
	input wire logic line_sync_input,
	input wire logic [7:0] timing_master_slave_select,
	input wire logic scan_begin_request,
	input wire logic standby_select,
	input wire logic [7:0] line_transfer_width,
	input wire logic [COUNT_W-1:0] line_end_count,
	input wire logic [COUNT_W-1:0] black_start,
	input wire logic [COUNT_W-1:0] black_end,
	input wire logic [COUNT_W-1:0] valid_start,
	input wire logic [COUNT_W-1:0] valid_end,
	input wire logic [2:0] colour_sel,
	input wire logic [2:0] link_test_mode,
	input wire logic [7:0] fixed_word_hi,
	input wire logic [7:0] fixed_word_mid,
	input wire logic [7:0] fixed_word_lo,
	input wire logic [SLTAG_DATA_W-1:0] pixel_data,
	output logic line_transfer_pulse_q,
	output logic [SLTAG_WORD_W-1:0] pixel_word_q,
	output logic word_strobe_q,
	output logic scan_active_q,
	output logic scan_request_pending_q
);

	// Reset release synchroniser
	logic [1:0] rst_sync_q;
	// Synchronised active-low reset for the rest of the block
	logic rst_n;

	// Assert at once, release after two edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Link clock and line sync synchronisers, plus a third stage for edges
	logic link_meta_q;
	logic link_sync_q;
	logic link_prev_q;
	logic sync_meta_q;
	logic sync_sync_q;
	logic sync_prev_q;
	// One-cycle events derived from the synchronised copies
	logic word_tick;
	logic sync_pulse;

	// Two flip-flops before any logic looks at the pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			link_meta_q <= 1'b0;
			link_sync_q <= 1'b0;
			link_prev_q <= 1'b0;
			sync_meta_q <= 1'b0;
			sync_sync_q <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			link_meta_q <= link_clk;
			link_sync_q <= link_meta_q;
			link_prev_q <= link_sync_q;
			sync_meta_q <= line_sync_input;
			sync_sync_q <= sync_meta_q;
			sync_prev_q <= sync_sync_q;
		end
	end

	// Rising link clock edge marks one pixel period and one word
	assign word_tick = link_sync_q & ~link_prev_q;
	// Rising sync edge starts a slave line
	assign sync_pulse = sync_sync_q & ~sync_prev_q;

	// Slave operation chosen by the select register
	logic slave_mode;
	assign slave_mode = timing_master_slave_select[SLTAG_MS_SLAVE_BIT]; // [R1]

	// Sequencer state
	sltag_state_e state_q;
	sltag_state_e state_d;
	// Pulse width or pixel counter, in pixel periods
	logic [COUNT_W-1:0] count_q;
	logic [COUNT_W-1:0] count_d;
	// Pending scan request, the self-clearing bit
	logic req_q;
	logic req_d;
	// Scan begin marker still owed to the stream
	logic bos_owed_q;
	logic bos_owed_d;
	// Pulse width with zero treated as one period
	logic [COUNT_W-1:0] width_ext;
	// Final pulse period of this line
	logic pulse_last;
	// Last pixel period of a master line
	logic line_last;
	// Scan may be started this cycle
	logic scan_go;
	// Standby stops a running master scan
	logic stop_scan;

	assign width_ext = (line_transfer_width == 8'h00) ?
		COUNT_W'(1) : COUNT_W'(line_transfer_width);
	assign pulse_last = word_tick && (count_q + COUNT_W'(1) >= width_ext);
	// Master line: width periods of pulse then line end periods [R4]
	assign line_last = word_tick && (count_q + COUNT_W'(1) >= line_end_count);
	// Master starts on the request; slave waits for the first sync [R5]
	assign scan_go = req_q && !standby_select &&
		(!slave_mode || sync_pulse);
	assign stop_scan = standby_select && !slave_mode; // [R3]

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		bos_owed_d = bos_owed_q;
		// A new write request wins over the clear of a taken one
		req_d = req_q;
		unique case (state_q)
			SLTAG_ST_IDLE: begin
				if (scan_go) begin
					// Request taken and cleared by hardware [R2]
					req_d = 1'b0;
					state_d = SLTAG_ST_PULSE;
					count_d = '0;
					bos_owed_d = 1'b1;
				end
			end
			SLTAG_ST_PULSE: begin
				if (stop_scan) begin
					state_d = SLTAG_ST_IDLE; // [R3]
				end else if (pulse_last) begin
					// Pulse falls; pixel count starts at zero [R6]
					state_d = SLTAG_ST_PIXELS;
					count_d = '0;
				end else if (word_tick) begin
					count_d = count_q + COUNT_W'(1);
				end
			end
			SLTAG_ST_PIXELS: begin
				if (stop_scan) begin
					state_d = SLTAG_ST_IDLE; // [R3]
				end else if (slave_mode && sync_pulse) begin
					// Slave line follows the incoming sync [R5]
					state_d = SLTAG_ST_PULSE;
					count_d = '0;
				end else if (!slave_mode && line_last) begin
					// Master starts the next line itself [R4]
					state_d = SLTAG_ST_PULSE;
					count_d = '0;
				end else if (word_tick && count_q != '1) begin
					// Saturates so a long slave line cannot wrap
					count_d = count_q + COUNT_W'(1);
				end
			end
			default: begin
				// Illegal code; fall back to idle
				state_d = SLTAG_ST_IDLE;
				count_d = '0;
			end
		endcase
		if (scan_begin_request) begin
			req_d = 1'b1; // [R2]
		end
		if (word_tick && state_q == SLTAG_ST_PIXELS) begin
			// First pixel word of the scan carries the marker
			bos_owed_d = 1'b0;
		end
		if (scan_go && state_q == SLTAG_ST_IDLE) begin
			bos_owed_d = 1'b1;
		end
	end

	// Sequencer registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SLTAG_ST_IDLE;
			count_q <= '0;
			req_q <= 1'b0;
			bos_owed_q <= 1'b0;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			req_q <= req_d;
			bos_owed_q <= bos_owed_d;
		end
	end

	// Low tag code for the current pixel
	logic [3:0] low_tag;
	// Pixel lies inside the black or valid window
	logic in_black;
	logic in_valid;

	// Window compare against the running pixel count [R6]
	assign in_black = (state_q == SLTAG_ST_PIXELS) &&
		(count_q >= black_start) && (count_q <= black_end);
	assign in_valid = (state_q == SLTAG_ST_PIXELS) &&
		(count_q >= valid_start) && (count_q <= valid_end);

	// Tag code selection; black window wins where both overlap
	always_comb begin
		low_tag = SLTAG_CODE_DUMMY;
		if (bos_owed_q && state_q == SLTAG_ST_PIXELS) begin
			low_tag = SLTAG_CODE_SCAN_BEGIN; // [R9]
		end else if (in_black) begin
			// Black code of the selected colour [R7]
			unique case (colour_sel)
				SLTAG_COL_RED: low_tag = SLTAG_CODE_RED_BLK;
				SLTAG_COL_GREEN: low_tag = SLTAG_CODE_GREEN_BLK;
				SLTAG_COL_BLUE: low_tag = SLTAG_CODE_BLUE_BLK;
				SLTAG_COL_IR1: low_tag = SLTAG_CODE_IR1_BLK;
				SLTAG_COL_IR2: low_tag = SLTAG_CODE_IR2_BLK;
				default: low_tag = SLTAG_CODE_DUMMY;
			endcase
		end else if (in_valid) begin
			// Active code of the selected colour [R8]
			unique case (colour_sel)
				SLTAG_COL_RED: low_tag = SLTAG_CODE_RED_ACT;
				SLTAG_COL_GREEN: low_tag = SLTAG_CODE_GREEN_ACT;
				SLTAG_COL_BLUE: low_tag = SLTAG_CODE_BLUE_ACT;
				SLTAG_COL_IR1: low_tag = SLTAG_CODE_IR1_ACT;
				SLTAG_COL_IR2: low_tag = SLTAG_CODE_IR2_ACT;
				default: low_tag = SLTAG_CODE_DUMMY;
			endcase
		end
	end

	// Test pattern source
	logic [SLTAG_WORD_W-1:0] pattern_word;
	// Fixed word from the three upcounter registers
	logic [SLTAG_WORD_W-1:0] fixed_word;
	// Pulse currently active
	logic pulse_active;

	assign fixed_word = {fixed_word_hi[4:0], fixed_word_mid, fixed_word_lo};
	assign pulse_active = (state_q == SLTAG_ST_PULSE);

	// Pattern generator resets under the pulse
	sltag_pattern_gen u_pattern (
		.clk(clk),
		.rst_n(rst_n),
		.word_tick(word_tick),
		.pulse_active(pulse_active), // [R13]
		.test_mode(link_test_mode),
		.fixed_word(fixed_word),
		.pattern_word(pattern_word)
	);

	// Test mode active
	logic test_on;
	// Word to send on this tick
	logic [SLTAG_WORD_W-1:0] word_d;
	logic strobe_d;
	logic pulse_out_d;
	logic active_d;

	assign test_on = (link_test_mode == SLTAG_TEST_ALTERNATE) ||
		(link_test_mode == SLTAG_TEST_RAMP) ||
		(link_test_mode == SLTAG_TEST_FIXED);

	// Output formatter: words leave only on link ticks, so the sampling
	// phase chosen upstream never shifts where a word sits [R18]
	always_comb begin
		word_d = pixel_word_q;
		strobe_d = word_tick;
		pulse_out_d = pulse_active;
		active_d = (state_q != SLTAG_ST_IDLE);
		if (word_tick) begin
			if (test_on) begin
				// All 21 bits are pattern, no tag coding [R12]
				word_d = pattern_word;
			end else begin
				// Top tag bit tracks the pulse; five tags on top [R10] [R11]
				word_d = {pulse_active, low_tag, pixel_data}; // [R20]
			end
		end
	end

	// Output registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pixel_word_q <= '0;
			word_strobe_q <= 1'b0;
			line_transfer_pulse_q <= 1'b0;
			scan_active_q <= 1'b0;
			scan_request_pending_q <= 1'b0;
		end else begin
			pixel_word_q <= word_d;
			word_strobe_q <= strobe_d;
			line_transfer_pulse_q <= pulse_out_d;
			scan_active_q <= active_d;
			scan_request_pending_q <= req_d;
		end
	end

endmodule : sltag_core
`default_nettype wire

/* verilog/sltag_pattern_gen.sv */
// Link test pattern generator for the scan line tagging output block
`timescale 1ns/100ps
`default_nettype none
module sltag_pattern_gen
	import sltag_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic word_tick,
	input wire logic pulse_active,
	input wire logic [2:0] test_mode,
	input wire logic [20:0] fixed_word,
	output logic [20:0] pattern_word
);

	// Alternating phase: low selects the base word
	logic alt_phase_q;
	logic alt_phase_d;
	// Ramp value
	logic [20:0] ramp_q;
	logic [20:0] ramp_d;
	// Previous mode, to catch a fresh ramp selection
	logic [2:0] mode_q;
	logic [2:0] mode_d;

	// Pattern advance and restart
	always_comb begin
		alt_phase_d = alt_phase_q;
		ramp_d = ramp_q;
		mode_d = test_mode;
		if (pulse_active) begin
			// Held at start while the pulse is active [R13] [R14]
			alt_phase_d = 1'b0;
			ramp_d = SLTAG_RAMP_START;
		end else if (word_tick) begin
			// Free running with no pulse; ramp wraps at full scale [R13] [R16]
			alt_phase_d = ~alt_phase_q;
			ramp_d = ramp_q + 21'h000001; // [R15]
		end
		if (test_mode == SLTAG_TEST_RAMP && mode_q != SLTAG_TEST_RAMP) begin
			// Fresh ramp selection restarts from zero at once [R16]
			ramp_d = SLTAG_RAMP_START;
		end
	end

	// Pattern state registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			alt_phase_q <= 1'b0;
			ramp_q <= SLTAG_RAMP_START;
			mode_q <= SLTAG_TEST_OFF;
		end else begin
			alt_phase_q <= alt_phase_d;
			ramp_q <= ramp_d;
			mode_q <= mode_d;
		end
	end

	// Word selection; the owner registers it on each tick
	always_comb begin
		unique case (test_mode)
			SLTAG_TEST_ALTERNATE: begin
				// Base word or its complement [R14]
				pattern_word = alt_phase_q ? ~SLTAG_ALT_WORD : SLTAG_ALT_WORD;
			end
			SLTAG_TEST_RAMP: begin
				pattern_word = ramp_q; // [R15]
			end
			SLTAG_TEST_FIXED: begin
				pattern_word = fixed_word; // [R17]
			end
			default: begin
				// Not a test mode; unused by the owner
				pattern_word = SLTAG_RAMP_START;
			end
		endcase
	end

endmodule : sltag_pattern_gen
`default_nettype wire

/* verilog/sltag_pkg.sv */
// Constants shared by the scan line tagging output block
package sltag_pkg;

	// Master/slave select register location and layout
	localparam logic [7:0] SLTAG_MS_SELECT_OFFSET = 8'h00;
	localparam int SLTAG_MS_SLAVE_BIT = 0;
	localparam logic [7:0] SLTAG_MS_SELECT_RESET = 8'h00;

	// Scan request bit position within main configuration 2
	localparam int SLTAG_SCAN_REQ_BIT = 0;

	// Black and valid pixel window register span on page 4
	localparam logic [7:0] SLTAG_WINDOW_FIRST_OFFSET = 8'h08;
	localparam logic [7:0] SLTAG_WINDOW_LAST_OFFSET = 8'h0D;

	// Output word layout: five tag bits above sixteen data bits
	localparam int SLTAG_DATA_W = 16;
	localparam int SLTAG_TAG_W = 5;
	localparam int SLTAG_WORD_W = 21;

	// Colour selections
	localparam logic [2:0] SLTAG_COL_RED = 3'h0;
	localparam logic [2:0] SLTAG_COL_GREEN = 3'h1;
	localparam logic [2:0] SLTAG_COL_BLUE = 3'h2;
	localparam logic [2:0] SLTAG_COL_IR1 = 3'h3;
	localparam logic [2:0] SLTAG_COL_IR2 = 3'h4;

	// Low tag codes
	localparam logic [3:0] SLTAG_CODE_DUMMY = 4'h0;
	localparam logic [3:0] SLTAG_CODE_RED_ACT = 4'h1;
	localparam logic [3:0] SLTAG_CODE_GREEN_ACT = 4'h2;
	localparam logic [3:0] SLTAG_CODE_BLUE_ACT = 4'h3;
	localparam logic [3:0] SLTAG_CODE_IR1_ACT = 4'h4;
	localparam logic [3:0] SLTAG_CODE_IR2_ACT = 4'h5;
	localparam logic [3:0] SLTAG_CODE_RED_BLK = 4'h6;
	localparam logic [3:0] SLTAG_CODE_GREEN_BLK = 4'h7;
	localparam logic [3:0] SLTAG_CODE_BLUE_BLK = 4'h8;
	localparam logic [3:0] SLTAG_CODE_IR1_BLK = 4'h9;
	localparam logic [3:0] SLTAG_CODE_IR2_BLK = 4'hA;
	localparam logic [3:0] SLTAG_CODE_SCAN_BEGIN = 4'hF;

	// Link test mode selections
	localparam logic [2:0] SLTAG_TEST_OFF = 3'h0;
	localparam logic [2:0] SLTAG_TEST_ALTERNATE = 3'h1;
	localparam logic [2:0] SLTAG_TEST_RAMP = 3'h2;
	localparam logic [2:0] SLTAG_TEST_FIXED = 3'h3;

	// Test pattern values
	localparam logic [20:0] SLTAG_ALT_WORD = 21'h155555;
	localparam logic [20:0] SLTAG_RAMP_START = 21'h000000;

	// Line sequencer states
	typedef enum logic [2:0] {
		SLTAG_ST_IDLE = 3'b001,
		SLTAG_ST_PULSE = 3'b010,
		SLTAG_ST_PIXELS = 3'b100
	} sltag_state_e;

endpackage : sltag_pkg
